// file: testbench/eewc_eeprom.sv
`timescale 1ns/1ps

// ****************************************
// Serial EEPROM target
// ****************************************
module eewc_eeprom (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack_addr,
    input  wire logic no_word,
    output logic      sda_oe
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr = 8'h00;
    int         bitn = 0;
    logic       act = 1'h0;
    logic       rd = 1'h0;
    logic       adr = 1'h0;
    logic       wa = 1'h0;

    initial
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5A;
    initial
        sda_oe = 1'h0;
    // Start or restart drops any byte in flight
    always @(negedge sda)
        if (scl)
            {act, adr, rd, sda_oe, bitn} = {4'hC, 32'h0};
    always @(posedge sda)
        if (scl)
            act = 1'h0;
    always @(posedge scl)
        if (act)
        begin
            sh = {sh[6:0], sda};
            act = !(bitn == 8 && rd && sda);
            bitn++;
        end
    // Drives only on the falling clock, so data never moves while it is high
    always @(negedge scl)
        if (act && bitn == 8 && !rd)
        begin
            if (!adr && wa)
                ptr = sh;
            else if (!adr)
                mem[ptr] = sh;
            ptr = (!adr && !wa) ? ptr + 8'h01 : ptr;
            wa = adr && !sh[0] && !no_word;
            rd = adr && sh[0];
            sda_oe = !adr || (sh[7:1] == 7'h50 && !nack_addr);
            act = sda_oe;
            adr = 1'h0;
        end
        else if (act && bitn == 9)
        begin
            bitn = 0;
            tx = mem[ptr];
            ptr = rd ? ptr + 8'h01 : ptr;
            sda_oe = rd && !tx[7];
        end
        else if (act)
            sda_oe = rd && bitn < 8 && !tx[7 - bitn];
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
    logic       clk = 1'h0, rst_n = 1'h0, cfg_we = 1'h0, sw_start = 1'h0, sw_read = 1'h0;
    logic       nack = 1'h1, noword = 1'h0, scl_oe, sda_oe, m_oe, sw_busy, sw_done;
    logic       prst_n = 1'h1, global_reset_n_n = 1'h1, scl_pd = 1'h0, scl_o, sda_o, load_valid;
    logic [7:0] cfg_addr = 8'hBC, cfg_wdata = 8'h00, sw_word_addr = 8'h00, sw_wdata = 8'h00;
    logic [7:0] cfg_rdata, sw_rdata;
    // Open drain: a pulled-low line reads low, a released one floats to the pull-up
    wire        scl = (scl_oe ? scl_o : 1'h1) & !scl_pd;
    wire        sda = (sda_oe ? sda_o : 1'h1) & !m_oe;
    int         n_errors = 0, tests_run = 0, cyc = 0;
    time        per = 0, last = 0;

    eewc_top eewc_top_i (
        .SYS_CLK(clk), .RST_N(rst_n), .CE(1'h1),
        .PCIE_RESET_N(prst_n), .GLOBAL_RESET_N(global_reset_n_n),
        .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .CFG_ADDR(cfg_addr), .CFG_WE(cfg_we), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
        .SW_START(sw_start), .SW_READ(sw_read), .SW_WORD_ADDR(sw_word_addr),
        .SW_WDATA(sw_wdata), .SW_RDATA(sw_rdata), .SW_BUSY(sw_busy), .SW_DONE(sw_done),
        .LOAD_VALID(load_valid), .LOAD_READY(1'h1), .LOAD_ADDR(), .LOAD_DATA());
    eewc_eeprom eewc_eeprom_i (.scl(scl), .sda(sda), .nack_addr(nack), .no_word(noword),
        .sda_oe(m_oe));

    initial
        forever #5 clk = ~clk;
    // Clock period from one low-pull of the clock line to the next
    always @(posedge scl_oe)
    begin
        per = $time - last;
        last = $time;
    end
    always @(posedge clk)
        if (++cyc == 130000)
        begin
            n_errors++;
            end_of_test();
        end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] d);
        @(negedge clk);
        {cfg_addr, cfg_wdata, cfg_we} = {eewc_pkg::REG_SB_CTRL, d, 1'h1};
        @(negedge clk);
        cfg_we = 1'h0;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        cfg_addr = a;
        repeat (2) @(negedge clk);
        `CHK(cfg_rdata, e)
    endtask
    task automatic sw_op(input logic r, input logic [7:0] a, input logic [7:0] d);
        int n;
        {sw_read, sw_word_addr, sw_wdata, sw_start} = {r, a, d, 1'h1};
        @(negedge clk);
        sw_start = 1'h0;
        `CHK(sw_busy, 1'h1)
        for (n = 0; n < 80000 && sw_done !== 1'h1; n++)
            @(negedge clk);
        `CHK(sw_done, 1'h1)
    endtask
    // Target refuses its address, so the download ends after one byte
    task automatic t_download();
        int n;
        for (n = 0; n < 30000 && (n < 40 || cfg_rdata[4] !== 1'h0); n++)
        begin
            @(negedge clk);
            sw_start = n == 1000;
            if (n == 1000)
                `CHK(cfg_rdata[4], 1'h1)
            if (n == 1001)
                `CHK(sw_busy, 1'h0)
        end
        `CHK(scl_oe, 1'h0)
        `CHK(load_valid, 1'h0)
        reg_chk(eewc_pkg::REG_SB_CTRL, 8'h0B);
    endtask
    task automatic t_write();
        reg_wr(8'h0B);
        nack = 1'h0;
        sw_op(1'h0, 8'h10, 8'hC3);
        `CHK(eewc_eeprom_i.mem[8'h10], 8'hC3)
        `CHK(per, 4 * eewc_pkg::QUARTER * 10)
        reg_chk(eewc_pkg::REG_SB_CTRL, 8'h08);
    endtask
    // Without word address the target reads from its advanced pointer
    task automatic t_read();
        reg_wr(8'h88);
        noword = 1'h1;
        sw_op(1'h1, 8'h00, 8'h00);
        `CHK(sw_rdata, 8'h4B)
        reg_chk(eewc_pkg::REG_SB_CTRL, 8'h88);
    endtask
    // Pull-up present at the first release only; the later release must decide
    task automatic t_pin_reset();
        @(negedge clk);
        {prst_n, global_reset_n_n} = 2'h0;
        repeat (8) @(negedge clk);
        prst_n = 1'h1;
        repeat (8) @(negedge clk);
        {scl_pd, global_reset_n_n} = 2'h3;
        repeat (12) @(negedge clk);
        scl_pd = 1'h0;
        reg_chk(eewc_pkg::REG_SB_CTRL, 8'h80);
    endtask
    task automatic t_disable();
        reg_wr(8'h80);
        reg_chk(eewc_pkg::REG_SB_CTRL, 8'h80);
        sw_start = 1'h1;
        @(negedge clk);
        sw_start = 1'h0;
        repeat (500) @(negedge clk);
        `CHK({sw_busy, scl_oe, sda_oe}, 3'h0)
        reg_chk(8'h00, 8'h00);
    endtask

    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        t_download();
        t_write();
        t_read();
        t_pin_reset();
        t_disable();
        end_of_test();
    end
endmodule

// file: verilog/eewc_pkg.sv
package eewc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_SB_CTRL  = 8'hBC;
    localparam int         BIT_PROTOCOL_SELECT = 7;
    localparam int         BIT_DL_BUSY  = 4;
    localparam int         BIT_PRESENT  = 3;
    localparam int         BIT_BUS_ERR  = 1;
    localparam int         BIT_DL_ERR   = 0;

    // ****************************************
    // Bus constants
    // ****************************************
    localparam logic [6:0] TARGET_ADDR   = 7'h50;
    localparam logic [7:0] ADDR_WR       = {TARGET_ADDR, 1'b0};
    localparam logic [7:0] ADDR_RD       = {TARGET_ADDR, 1'b1};
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT       = 4'h8;

    // ****************************************
    // Download image layout
    // ****************************************
    localparam logic [7:0] WA_FUNC  = 8'h00;
    localparam logic [7:0] WA_COUNT = 8'h01;
    localparam logic [7:0] WA_FIRST = 8'h02;
    localparam logic [7:0] FUNC_IND = 8'h00;
    localparam logic [7:0] END_MARK = 8'h80;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         CLK_HZ   = 100_000_000;
    localparam int         SCL_HZ   = 60_000;
    localparam int         QUARTER  = CLK_HZ / (4 * SCL_HZ);
    localparam logic [8:0] QTR_LAST = 9'(QUARTER - 1);

    // ****************************************
    // Synchroniser bit positions
    // ****************************************
    localparam int PIN_SCL  = 0;
    localparam int PIN_SDA  = 1;
    localparam int PIN_PRST = 2;
    localparam int PIN_GLOBAL_RESET_N = 3;

    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BYTE, ST_STOP} eewc_state_e;
    typedef enum logic [2:0] {STEP_DEVW, STEP_WADDR, STEP_DATAW, STEP_DEVR, STEP_READ} eewc_step_e;

endpackage

// file: verilog/eewc_top.sv
`timescale 1ns/1ps

// ****************************************
// Download FIFO
// ****************************************
module eewc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } eewc_fifo_s;

    eewc_fifo_s q;
    eewc_fifo_s d;
    logic       wr_en;
    logic       rd_en;

    assign in_ready  = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data  = q.mem[q.rd];
    assign wr_en     = in_valid && in_ready;
    assign rd_en     = out_valid && out_ready;

    always_comb
    begin
        d = q;
        if (wr_en)
        begin
            d.mem[q.wr] = in_data;
            d.wr        = q.wr + 1'b1;
        end
        if (rd_en)
            d.rd = q.rd + 1'b1;
        d.cnt = q.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            q <= '0;
        else if (ce)
            q <= d;
    end
endmodule

// ****************************************
// Serial EEPROM controller
// ****************************************
// Operation
// - Sample SCL pull-up at reset release
// - Writing zero to present disables bus
// - SCL output only, both open drain
// - SCL near 60 kHz, released when idle
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - SDA changes only while SCL low
// - Eight-bit bytes, each followed by acknowledge
// - Acknowledge is SDA low during SCL high
// - Software single bytes, download multibyte reads
// - Write: address, word address, data, stop
// - Address not acknowledged sets bus error
// - Read: restart, read address, no-acknowledge, stop
// - Multibyte read acknowledges until last byte
// - Protocol select drops word address byte
// - Busy during download, error flag after
// - Fixed target address 1010 000
// - Function word, count word, end marker
// - Downloaded bytes go to register bytes
module eewc_top (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire logic       CE,
    input  wire logic       PCIE_RESET_N,
    input  wire logic       GLOBAL_RESET_N,
    input  wire logic       SCL_I,
    output logic            SCL_O,
    output logic            SCL_OE,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE,
    input  wire logic [7:0] CFG_ADDR,
    input  wire logic       CFG_WE,
    input  wire logic [7:0] CFG_WDATA,
    output logic      [7:0] CFG_RDATA,
    input  wire logic       SW_START,
    input  wire logic       SW_READ,
    input  wire logic [7:0] SW_WORD_ADDR,
    input  wire logic [7:0] SW_WDATA,
    output logic      [7:0] SW_RDATA,
    output logic            SW_BUSY,
    output logic            SW_DONE,
    output logic            LOAD_VALID,
    input  wire logic       LOAD_READY,
    output logic      [7:0] LOAD_ADDR,
    output logic      [7:0] LOAD_DATA
);
    typedef struct packed {
        logic [3:0]           s1;
        logic [3:0]           s2;
        logic [3:0]           s3;
        logic [3:0]           pin;
        logic                 rst_done;
        logic                 present;
        logic                 protocol_select;
        logic                 bus_err;
        logic                 dl_err;
        logic                 dl_busy;
        eewc_pkg::eewc_state_e state;
        eewc_pkg::eewc_step_e  step;
        logic [1:0]           ph;
        logic [8:0]           qcnt;
        logic [3:0]           bitn;
        logic [7:0]           shreg;
        logic [7:0]           waddr;
        logic [7:0]           count;
        logic [7:0]           wdata;
        logic [7:0]           rdata;
        logic [7:0]           cfg_rdata;
        logic                 is_read;
        logic                 sw_op;
        logic                 nack;
        logic                 ack;
        logic                 sw_done;
        logic                 scl_low;
        logic                 sda_low;
    } eewc_top_s;

    eewc_top_s   q;
    eewc_top_s   d;
    logic        push;
    logic [15:0] push_data;
    logic [7:0]  rx_byte;
    logic [7:0]  status;
    logic        fail;
    logic        fifo_in_ready;
    logic [15:0] fifo_out;
    logic        cfg_hit;
    logic        byte_end;

    assign cfg_hit  = CFG_ADDR == eewc_pkg::REG_SB_CTRL;
    assign byte_end = q.state == eewc_pkg::ST_BYTE && q.qcnt == '0 && q.ph == 2'd3
                      && q.bitn == eewc_pkg::ACK_BIT;

    always_comb
    begin
        d         = q;
        push      = 1'b0;
        rx_byte   = {q.shreg[6:0], q.pin[eewc_pkg::PIN_SDA]};
        push_data = {q.waddr, rx_byte};
        fail      = q.nack && q.step != eewc_pkg::STEP_READ;
        d.sw_done = 1'b0;
        // Three-stage sync; a pin moves only once stages two and three agree
        d.s1  = {GLOBAL_RESET_N, PCIE_RESET_N, SDA_I, SCL_I};
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.pin = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.pin);

        status = '0;
        status[eewc_pkg::BIT_PROTOCOL_SELECT] = q.protocol_select;
        status[eewc_pkg::BIT_DL_BUSY]  = q.dl_busy;
        status[eewc_pkg::BIT_PRESENT]  = q.present;
        status[eewc_pkg::BIT_BUS_ERR]  = q.bus_err;
        status[eewc_pkg::BIT_DL_ERR]   = q.dl_err;
        d.cfg_rdata = cfg_hit ? status : '0;

        // Error bits clear on writing one; later hardware sets win
        if (CFG_WE && cfg_hit)
        begin
            d.protocol_select = CFG_WDATA[eewc_pkg::BIT_PROTOCOL_SELECT];
            if (!CFG_WDATA[eewc_pkg::BIT_PRESENT])
                d.present = 1'b0;
            if (CFG_WDATA[eewc_pkg::BIT_BUS_ERR])
                d.bus_err = 1'b0;
            if (CFG_WDATA[eewc_pkg::BIT_DL_ERR])
                d.dl_err = 1'b0;
        end

        if (!(q.pin[eewc_pkg::PIN_PRST] && q.pin[eewc_pkg::PIN_GLOBAL_RESET_N]))
        begin
            d.rst_done = 1'b0;
            d.present  = 1'b0;
            d.dl_busy  = 1'b0;
            d.state    = eewc_pkg::ST_IDLE;
        end
        else if (!q.rst_done)
        begin
            d.rst_done = 1'b1;
            d.present  = q.pin[eewc_pkg::PIN_SCL];
            if (q.pin[eewc_pkg::PIN_SCL])
            begin
                d.dl_busy = 1'b1;
                d.dl_err  = 1'b0;
                d.sw_op   = 1'b0;
                d.is_read = 1'b1;
                d.waddr   = eewc_pkg::WA_FUNC;
                d.state   = eewc_pkg::ST_START;
                d.step    = eewc_pkg::STEP_DEVW;
                d.ph      = 2'd0;
                d.qcnt    = eewc_pkg::QTR_LAST;
            end
        end
        else if (!q.present)
        begin
            d.state   = eewc_pkg::ST_IDLE;
            d.dl_busy = 1'b0;
        end
        else if (q.state == eewc_pkg::ST_IDLE)
        begin
            if (SW_START)
            begin
                d.sw_op   = 1'b1;
                d.is_read = SW_READ;
                d.waddr   = SW_WORD_ADDR;
                d.wdata   = SW_WDATA;
                d.state   = eewc_pkg::ST_START;
                d.step    = eewc_pkg::STEP_DEVW;
                d.ph      = 2'd0;
                d.qcnt    = eewc_pkg::QTR_LAST;
            end
        end
        else if (q.state == eewc_pkg::ST_BYTE && q.step == eewc_pkg::STEP_READ && !q.sw_op
                 && q.bitn == '0 && q.ph == 2'd0 && !fifo_in_ready)
        begin
            // FIFO full: hold SCL low before the next byte
        end
        else if (q.qcnt != '0)
            d.qcnt = q.qcnt - 9'd1;
        else
        begin
            d.qcnt = eewc_pkg::QTR_LAST;
            d.ph   = q.ph + 2'd1;
            unique case (q.state)
                eewc_pkg::ST_IDLE:
                    d.state = eewc_pkg::ST_IDLE;
                eewc_pkg::ST_START:
                    if (q.ph == 2'd3)
                    begin
                        d.state = eewc_pkg::ST_BYTE;
                        d.bitn  = '0;
                        d.shreg = (q.step == eewc_pkg::STEP_DEVR) ? eewc_pkg::ADDR_RD
                                                                  : eewc_pkg::ADDR_WR;
                    end
                eewc_pkg::ST_STOP:
                    if (q.ph == 2'd3)
                    begin
                        d.state   = eewc_pkg::ST_IDLE;
                        d.dl_busy = 1'b0;
                        d.sw_done = q.sw_op;
                    end
                eewc_pkg::ST_BYTE:
                begin
                    if (q.ph == 2'd2)
                    begin
                        if (q.bitn == eewc_pkg::ACK_BIT)
                            d.nack = q.pin[eewc_pkg::PIN_SDA];
                        else if (q.step == eewc_pkg::STEP_READ)
                            d.shreg = rx_byte;
                        if (q.step == eewc_pkg::STEP_READ && q.bitn == eewc_pkg::LAST_DATA_BIT)
                        begin
                            if (q.sw_op)
                            begin
                                d.rdata = rx_byte;
                                d.ack   = 1'b0;
                            end
                            else
                            begin
                                d.ack   = 1'b1;
                                d.waddr = q.waddr + 8'd1;
                                if (q.waddr == eewc_pkg::WA_FUNC)
                                begin
                                    if (rx_byte != eewc_pkg::FUNC_IND)
                                    begin
                                        d.dl_err = 1'b1;
                                        d.ack    = 1'b0;
                                    end
                                end
                                else if (q.waddr == eewc_pkg::WA_COUNT)
                                    d.count = rx_byte;
                                else if (q.waddr == 8'(q.count + eewc_pkg::WA_FIRST))
                                begin
                                    d.ack = 1'b0;
                                    if (rx_byte != eewc_pkg::END_MARK)
                                        d.dl_err = 1'b1;
                                end
                                else
                                    push = 1'b1;
                            end
                        end
                    end
                    if (q.ph == 2'd3)
                    begin
                        d.bitn = q.bitn + 4'd1;
                        if (q.step != eewc_pkg::STEP_READ && q.bitn != eewc_pkg::ACK_BIT)
                            d.shreg = {q.shreg[6:0], 1'b0};
                        if (q.bitn == eewc_pkg::ACK_BIT)
                        begin
                            d.bitn = '0;
                            if (fail)
                            begin
                                d.state   = eewc_pkg::ST_STOP;
                                d.bus_err = 1'b1;
                                if (!q.sw_op)
                                    d.dl_err = 1'b1;
                            end
                            else
                                unique case (q.step)
                                    eewc_pkg::STEP_DEVW:
                                        if (!q.protocol_select)
                                        begin
                                            d.step  = eewc_pkg::STEP_WADDR;
                                            d.shreg = q.waddr;
                                        end
                                        else if (q.is_read)
                                        begin
                                            d.state = eewc_pkg::ST_START;
                                            d.step  = eewc_pkg::STEP_DEVR;
                                        end
                                        else
                                        begin
                                            d.step  = eewc_pkg::STEP_DATAW;
                                            d.shreg = q.wdata;
                                        end
                                    eewc_pkg::STEP_WADDR:
                                        if (q.is_read)
                                        begin
                                            d.state = eewc_pkg::ST_START;
                                            d.step  = eewc_pkg::STEP_DEVR;
                                        end
                                        else
                                        begin
                                            d.step  = eewc_pkg::STEP_DATAW;
                                            d.shreg = q.wdata;
                                        end
                                    eewc_pkg::STEP_DATAW:
                                        d.state = eewc_pkg::ST_STOP;
                                    eewc_pkg::STEP_DEVR:
                                        d.step = eewc_pkg::STEP_READ;
                                    eewc_pkg::STEP_READ:
                                        if (!q.ack)
                                            d.state = eewc_pkg::ST_STOP;
                                endcase
                        end
                    end
                end
            endcase
        end

        // SDA held through each phase 0 so it never moves with the SCL edge
        d.scl_low = d.state != eewc_pkg::ST_IDLE && d.ph < 2'd2;
        unique case (d.state)
            eewc_pkg::ST_IDLE:
                d.sda_low = 1'b0;
            eewc_pkg::ST_START:
                d.sda_low = (d.ph == 2'd0) ? q.sda_low : d.ph == 2'd3;
            eewc_pkg::ST_STOP:
                d.sda_low = (d.ph == 2'd0) ? q.sda_low : d.ph != 2'd3;
            eewc_pkg::ST_BYTE:
                if (d.ph == 2'd0)
                    d.sda_low = q.sda_low;
                else if (d.bitn == eewc_pkg::ACK_BIT)
                    d.sda_low = d.step == eewc_pkg::STEP_READ && d.ack;
                else
                    d.sda_low = d.step != eewc_pkg::STEP_READ && !d.shreg[7];
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            q <= '0;
        else if (CE)
            q <= d;
    end

    eewc_fifo #(
        .WIDTH (eewc_pkg::FIFO_WIDTH),
        .DEPTH (eewc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (LOAD_VALID),
        .out_ready (LOAD_READY),
        .out_data  (fifo_out)
    );

    assign SCL_O     = 1'b0;
    assign SDA_O     = 1'b0;
    assign SCL_OE    = q.scl_low;
    assign SDA_OE    = q.sda_low;
    assign CFG_RDATA = q.cfg_rdata;
    assign SW_RDATA  = q.rdata;
    assign SW_BUSY   = q.sw_op && q.state != eewc_pkg::ST_IDLE;
    assign SW_DONE   = q.sw_done;
    assign LOAD_ADDR = fifo_out[15:8];
    assign LOAD_DATA = fifo_out[7:0];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N || !CE);

    sequence s_scl_high;
        !SCL_OE [*4];
    endsequence

    AST_IDLE_FREE: assert property (q.state == eewc_pkg::ST_IDLE |-> !SCL_OE && !SDA_OE)
        else $error("Bus not released while idle");
    AST_SDA_CHANGE: assert property ($changed(SDA_OE) |-> SCL_OE || q.state inside
        {eewc_pkg::ST_START, eewc_pkg::ST_STOP})
        else $error("SDA moved while SCL high");
    AST_START: assert property (q.state == eewc_pkg::ST_START && $rose(SDA_OE) |-> s_scl_high)
        else $error("Start without SCL high");
    AST_STOP: assert property (q.state == eewc_pkg::ST_STOP && $fell(SDA_OE) |-> s_scl_high)
        else $error("Stop without SCL high");
    AST_DETECT: assert property ($rose(q.rst_done)
        |-> q.present == $past(q.pin[eewc_pkg::PIN_SCL]))
        else $error("Pull-up not sampled at reset release");
    AST_DISABLE: assert property (CFG_WE && cfg_hit && !CFG_WDATA[eewc_pkg::BIT_PRESENT]
        |=> ##1 (q.state == eewc_pkg::ST_IDLE && !SCL_OE))
        else $error("Bus active after disable");
    AST_ERR_NACK: assert property (byte_end && q.step == eewc_pkg::STEP_DEVW && q.nack
        |=> q.bus_err && q.state == eewc_pkg::ST_STOP)
        else $error("Address nack not flagged");
    AST_PROT_SKIP: assert property (byte_end && q.step == eewc_pkg::STEP_DEVW && !q.nack
        && q.protocol_select && !q.is_read |=> q.step == eewc_pkg::STEP_DATAW)
        else $error("Word address not skipped");
    AST_BUSY: assert property (q.dl_busy |-> q.state != eewc_pkg::ST_IDLE)
        else $error("Download busy while idle");
    AST_SW_BLOCK: assert property (SW_START && q.dl_busy |=> !q.sw_op)
        else $error("Software op during download");
    AST_RX_RELEASE: assert property (q.state == eewc_pkg::ST_BYTE && q.ph == 2'd2
        && (q.step == eewc_pkg::STEP_READ) != (q.bitn == eewc_pkg::ACK_BIT) |-> !SDA_OE)
        else $error("SDA driven while target drives");
    AST_NOACK_LAST: assert property (q.sw_op && q.step == eewc_pkg::STEP_READ
        && q.state == eewc_pkg::ST_BYTE && q.bitn == eewc_pkg::ACK_BIT && q.ph == 2'd2 |-> !SDA_OE)
        else $error("Single read acknowledged");
endmodule
